// [src/phy_status_and_tenbase_ctrl_regs.sv]
/*
 * quick-poll status and 10base-t operations registers behind a serial
 * management slave. assumes status inputs come from the datapath in the
 * i_core_clk domain; mdc, mdio and straps are pins and get synchronised here.
 */
// Function
// - the three-bit negotiation progress code sits at bits 13:11, read-only, reset zero.
// - a premature stream end of two idle symbols latches a flag high.
// - a received halt code group latches a flag high.
// - a carrier start without a valid stream start latches a flag high.
// - a remote fault from the partner latches a read-only flag high, reset zero.
// - a far-end jabber in 10base-t latches a flag high, reset zero.
// - reversed polarity is corrected unless inhibited and is latched high.
// - the receive tri-state control releases the rmii receive outputs when one.
// - vendor registers 25 to 31 are reachable only while the gate control is zero.
// - the sqe test runs after transmit unless its inhibit is one.
// - the link-loss inhibit forces 10base-t link pass.
// - a read-write test bit, reset zero, picks the test multiplexer path.
`timescale 1ns/1ps
module phy_status_and_tenbase_ctrl_regs #(
    parameter logic [4:0] PHY_ADDR = phy_mgmt_pkg::PHY_ADDR_DFLT,
    parameter int         PRE_LEN  = phy_mgmt_pkg::PREAMBLE_LEN
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_srst,
    input  wire logic                     i_mdc,
    input  wire logic                     i_mdio,
    output logic                          o_mdio,
    output logic                          o_mdio_oe,
    input  wire logic [2:0]               i_strap,
    input  wire phy_mgmt_pkg::status_in_t i_stat,
    output phy_mgmt_pkg::ctrl_out_t       o_ctrl
);
    typedef enum logic [4:0] {
        S_PRE  = 5'h01,
        S_ST   = 5'h02,
        S_HDR  = 5'h04,
        S_TA   = 5'h08,
        S_DATA = 5'h10
    } mgmt_state_t;

    mgmt_state_t state;
    logic [2:0]  mdc_sync;
    logic [1:0]  mdio_sync;
    logic [5:0]  strap_s1;
    logic [2:0]  strap_s2;
    logic        strap_pending;
    logic        mdc_rise;
    logic        bit_in;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic [11:0] hdr;
    logic [15:0] shreg;
    logic        is_read;
    logic        hit;
    logic [15:0] ops;
    logic [2:0]  an_q;
    logic [3:0]  live_q;
    logic        rd_qp;
    logic        rd_ops;
    logic        link_eff;
    logic        link_val;
    logic [phy_mgmt_pkg::N_LH-1:0] lh_cond;
    logic [phy_mgmt_pkg::N_LH-1:0] lh_val;
    logic [15:0] qp_word;
    logic [15:0] ops_word;
    logic [15:0] rd_word;
    logic [4:0]  hdr_reg;

    // pins cross into the core clock
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mdc_sync  <= 3'h0;
            mdio_sync <= 2'h3;
        end else begin
            mdc_sync  <= {mdc_sync[1:0], i_mdc};
            mdio_sync <= {mdio_sync[0], i_mdio};
        end
    end
    assign mdc_rise = mdc_sync[1] & !mdc_sync[2];
    assign bit_in   = mdio_sync[1];

    always_ff @(posedge i_core_clk) begin
        strap_s1 <= {strap_s1[2:0], i_strap};
        strap_s2 <= strap_s1[5:3];
    end

    // datapath-facing status
    assign link_eff = i_stat.link_ok | ops[phy_mgmt_pkg::OP_LLOSS_INH];

    always_comb begin
        lh_cond = '0;
        lh_cond[phy_mgmt_pkg::LH_TXLOST] = i_stat.tx_signal_lost;
        lh_cond[phy_mgmt_pkg::LH_PLL]    = i_stat.pll_lock_err;
        lh_cond[phy_mgmt_pkg::LH_FCAR]   = i_stat.false_carrier;
        lh_cond[phy_mgmt_pkg::LH_INVSYM] = i_stat.invalid_symbol;
        lh_cond[phy_mgmt_pkg::LH_HALT]   = i_stat.halt_symbol;
        lh_cond[phy_mgmt_pkg::LH_PREEND] = i_stat.premature_end;
        lh_cond[phy_mgmt_pkg::LH_JAB]    = i_stat.jabber
                                           & !ops[phy_mgmt_pkg::OP_JAB_INH];
        lh_cond[phy_mgmt_pkg::LH_RFAULT] = i_stat.remote_fault;
        lh_cond[phy_mgmt_pkg::LH_RJAB]   = i_stat.remote_jabber;
        lh_cond[phy_mgmt_pkg::LH_POLREV] = i_stat.polarity_reversed;
    end

    genvar gi;
    generate
        for (gi = 0; gi < phy_mgmt_pkg::N_LH; gi++) begin : g_lh
            latch_flag #(.LATCH_LOW(1'b0)) u_flag (
                .i_core_clk (i_core_clk),
                .i_srst     (i_srst),
                .i_cond     (lh_cond[gi]),
                .i_clr      (gi >= phy_mgmt_pkg::LH_RJAB ? rd_ops : rd_qp),
                .o_val      (lh_val[gi])
            );
        end
    endgenerate

    latch_flag #(.LATCH_LOW(1'b1)) u_link (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_cond     (link_eff),
        .i_clr      (rd_qp),
        .o_val      (link_val)
    );

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            an_q   <= 3'h0;
            live_q <= 4'h0;
        end else begin
            an_q   <= i_stat.an_progress;
            live_q <= {i_stat.rate_100, i_stat.full_duplex,
                       i_stat.an_complete, i_stat.no_signal};
        end
    end

    assign qp_word = {live_q[3:2], an_q,
                      lh_val[phy_mgmt_pkg::LH_TXLOST], lh_val[phy_mgmt_pkg::LH_PLL],
                      lh_val[phy_mgmt_pkg::LH_FCAR], lh_val[phy_mgmt_pkg::LH_INVSYM],
                      lh_val[phy_mgmt_pkg::LH_HALT], lh_val[phy_mgmt_pkg::LH_PREEND],
                      live_q[1:0], lh_val[phy_mgmt_pkg::LH_JAB],
                      lh_val[phy_mgmt_pkg::LH_RFAULT], link_val};
    assign ops_word = {lh_val[phy_mgmt_pkg::LH_RJAB], lh_val[phy_mgmt_pkg::LH_POLREV],
                       phy_mgmt_pkg::BUSMODE_RMII, ops[11:0]};

    // vendor window reads back zero, gated or not, as any unmapped register does
    always_comb begin
        case (hdr_reg)
            phy_mgmt_pkg::ADDR_QP_STATUS: rd_word = qp_word;
            phy_mgmt_pkg::ADDR_TB_OPS:    rd_word = ops_word;
            default:                      rd_word = 16'h0000;
        endcase
    end
    assign hdr_reg = hdr[4:0];

    // operations register; straps load bits 11:9 once after reset release
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ops           <= phy_mgmt_pkg::OPS_RESET;
            strap_pending <= 1'b1;
        end else if (strap_pending) begin
            ops[11:9]     <= strap_s2;
            strap_pending <= 1'b0;
        end else if (mdc_rise && state == S_DATA && !is_read && hit && cnt == 5'd15
                     && hdr_reg == phy_mgmt_pkg::ADDR_TB_OPS) begin
            ops[11:0] <= {shreg[10:0], bit_in} & phy_mgmt_pkg::OPS_WR_MASK[11:0];
        end
    end

    // serial management frame engine
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state     <= S_PRE;
            ones      <= 6'h00;
            cnt       <= 5'h00;
            hdr       <= 12'h000;
            shreg     <= 16'h0000;
            is_read   <= 1'b0;
            hit       <= 1'b0;
            o_mdio    <= 1'b1;
            o_mdio_oe <= 1'b0;
            rd_qp     <= 1'b0;
            rd_ops    <= 1'b0;
        end else begin
            rd_qp  <= 1'b0;
            rd_ops <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    S_PRE: begin
                        o_mdio_oe <= 1'b0;
                        if (bit_in) begin
                            ones <= (ones == 6'h3f) ? ones : ones + 6'h01;
                        end else if (ones >= 6'(PRE_LEN)) begin
                            state <= S_ST;
                        end else begin
                            ones <= 6'h00;
                        end
                    end
                    S_ST: begin
                        ones  <= 6'h00;
                        cnt   <= 5'h00;
                        state <= bit_in ? S_HDR : S_PRE;
                    end
                    S_HDR: begin
                        hdr <= {hdr[10:0], bit_in};
                        cnt <= cnt + 5'h01;
                        if (cnt == 5'd11) begin
                            is_read <= hdr[10:9] == phy_mgmt_pkg::OP_READ;
                            hit     <= hdr[8:4] == PHY_ADDR;
                            cnt     <= 5'h00;
                            state   <= S_TA;
                        end
                    end
                    S_TA: begin
                        cnt <= cnt + 5'h01;
                        if (cnt == 5'd1) begin
                            cnt   <= 5'h00;
                            state <= S_DATA;
                        end else if (is_read && hit) begin
                            o_mdio    <= 1'b0;
                            o_mdio_oe <= 1'b1;
                            shreg     <= rd_word;
                            rd_qp     <= hdr_reg == phy_mgmt_pkg::ADDR_QP_STATUS;
                            rd_ops    <= hdr_reg == phy_mgmt_pkg::ADDR_TB_OPS;
                        end
                    end
                    S_DATA: begin
                        cnt <= cnt + 5'h01;
                        if (is_read && hit) begin
                            o_mdio <= shreg[15];
                            shreg  <= {shreg[14:0], 1'b0};
                        end else begin
                            shreg <= {shreg[14:0], bit_in};
                        end
                        if (cnt == 5'd16) begin
                            o_mdio_oe <= 1'b0;
                            o_mdio    <= 1'b1;
                            state     <= S_PRE;
                            ones      <= 6'h00;
                        end
                    end
                    default: state <= S_PRE;
                endcase
            end
        end
    end

    // controls out, all registered
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ctrl <= '0;
        end else begin
            o_ctrl.auto_crossover_enable <= ops[phy_mgmt_pkg::OP_XOVER];
            o_ctrl.rx_out_en        <= !ops[phy_mgmt_pkg::OP_RX_TRISTATE];
            o_ctrl.vendor_access_en <= !ops[phy_mgmt_pkg::OP_VGATE];
            o_ctrl.test_mux_select  <= ops[phy_mgmt_pkg::OP_TMUX];
            o_ctrl.jabber_check_en  <= !ops[phy_mgmt_pkg::OP_JAB_INH];
            o_ctrl.polarity_invert  <= i_stat.polarity_reversed
                                       & !ops[phy_mgmt_pkg::OP_APOL_INH];
            o_ctrl.sqe_test_en      <= !ops[phy_mgmt_pkg::OP_SQE_INH];
            o_ctrl.link_force_pass  <= ops[phy_mgmt_pkg::OP_LLOSS_INH];
            o_ctrl.squelch_en       <= !ops[phy_mgmt_pkg::OP_SQL_INH];
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    AST_AN_PROGRESS: assert property (##1 qp_word[13:11] == $past(i_stat.an_progress))
        else $error("progress code not reported");
    AST_PREMATURE: assert property (i_stat.premature_end |=> qp_word[5])
        else $error("premature end not latched");
    AST_HALT: assert property (i_stat.halt_symbol ##1 !rd_qp |-> qp_word[6][*2])
        else $error("halt flag not held");
    AST_FALSE_CARRIER: assert property (i_stat.false_carrier |=> qp_word[8])
        else $error("false carrier not latched");
    AST_REMOTE_FAULT: assert property (i_stat.remote_fault |=> qp_word[1])
        else $error("remote fault not latched");
    AST_REMOTE_JABBER: assert property (i_stat.remote_jabber |=> ops_word[15])
        else $error("remote jabber not latched");
    AST_POLARITY: assert property (i_stat.polarity_reversed
        && !ops[phy_mgmt_pkg::OP_APOL_INH] |=> o_ctrl.polarity_invert && ops_word[14])
        else $error("polarity not corrected or latched");
    AST_RX_TRISTATE: assert property (ops[phy_mgmt_pkg::OP_RX_TRISTATE]
        |=> !o_ctrl.rx_out_en)
        else $error("rmii receive still driven");
    AST_VENDOR_GATE: assert property (ops[phy_mgmt_pkg::OP_VGATE]
        |=> !o_ctrl.vendor_access_en)
        else $error("vendor access not gated");
    AST_SQE: assert property (!ops[phy_mgmt_pkg::OP_SQE_INH] |=> o_ctrl.sqe_test_en)
        else $error("sqe test suppressed");
    AST_LINK_FORCE: assert property (ops[phy_mgmt_pkg::OP_LLOSS_INH] && qp_word[0]
        |=> qp_word[0])
        else $error("link not forced to pass");
    AST_TMUX: assert property ($rose(ops[phy_mgmt_pkg::OP_TMUX]) |=> o_ctrl.test_mux_select)
        else $error("test mux select not routed");
    AST_LH_HOLD: assert property (qp_word[2] && !rd_qp |=> qp_word[2])
        else $error("latched flag dropped without read");
    AST_LINK_LOW: assert property (!link_eff
        |=> !qp_word[0] ##1 (!qp_word[0] || $past(rd_qp)))
        else $error("link loss not held low");
    AST_JABBER_INH: assert property (ops[phy_mgmt_pkg::OP_JAB_INH] && !qp_word[2]
        |=> !qp_word[2])
        else $error("jabber flagged while inhibited");

    COV_READ: cover property (state == S_TA && mdc_rise && is_read && hit && cnt == 5'd0);
    COV_WRITE: cover property (state == S_DATA && mdc_rise && !is_read && hit && cnt == 5'd15);
    COV_READ_CLEAR: cover property (rd_qp && qp_word[5] ##1 !qp_word[5]);
endmodule

// [src/phy_mgmt_pkg.sv]
/*
 * constants, field positions and carrier types for the quick-poll status
 * and 10base-t operations registers. assumes a 16-bit management word.
 */
package phy_mgmt_pkg;
    localparam logic [4:0]  ADDR_QP_STATUS  = 5'h11;
    localparam logic [4:0]  ADDR_TB_OPS     = 5'h12;
    localparam logic [4:0]  ADDR_VENDOR_LO  = 5'h19;
    localparam logic [4:0]  ADDR_VENDOR_HI  = 5'h1f;
    localparam logic [4:0]  PHY_ADDR_DFLT   = 5'h01;
    localparam int          PREAMBLE_LEN    = 32;
    localparam logic [1:0]  OP_READ         = 2'h2;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    // quick-poll status positions
    localparam int QP_RATE = 15;
    localparam int QP_DUPLEX = 14;
    localparam int QP_AN_LSB = 11;
    localparam int QP_LINK = 0;
    localparam int QP_AN_DONE = 4;
    localparam int QP_NO_SIGNAL = 3;
    // operations register positions
    localparam int OP_RJAB = 15;
    localparam int OP_POLREV = 14;
    localparam int OP_BUSMODE_LSB = 12;
    localparam int OP_XOVER = 11;
    localparam int OP_RX_TRISTATE = 10;
    localparam int OP_VGATE = 9;
    localparam int OP_TMUX = 8;
    localparam int OP_JAB_INH = 5;
    localparam int OP_RSVD1 = 4;
    localparam int OP_APOL_INH = 3;
    localparam int OP_SQE_INH = 2;
    localparam int OP_LLOSS_INH = 1;
    localparam int OP_SQL_INH = 0;
    localparam logic [1:0]  BUSMODE_RMII    = 2'h2;
    localparam logic [15:0] OPS_RESET       = 16'h0010;
    // 13:12 and 7:6 are fixed read values, everything else below 14 is writable
    localparam logic [15:0] OPS_WR_MASK     = 16'h0f3f;
    localparam logic [15:0] QP_RESET        = 16'h0000;
    // latched-high events, index -> bit of lh_cond and lh_val
    localparam int N_LH = 10;
    localparam int LH_TXLOST = 0;
    localparam int LH_PLL = 1;
    localparam int LH_FCAR = 2;
    localparam int LH_INVSYM = 3;
    localparam int LH_HALT = 4;
    localparam int LH_PREEND = 5;
    localparam int LH_JAB = 6;
    localparam int LH_RFAULT = 7;
    localparam int LH_RJAB = 8;
    localparam int LH_POLREV = 9;

    typedef struct packed {
        logic       rate_100;
        logic       full_duplex;
        logic [2:0] an_progress;
        logic       tx_signal_lost;
        logic       pll_lock_err;
        logic       false_carrier;
        logic       invalid_symbol;
        logic       halt_symbol;
        logic       premature_end;
        logic       an_complete;
        logic       no_signal;
        logic       jabber;
        logic       remote_fault;
        logic       link_ok;
        logic       remote_jabber;
        logic       polarity_reversed;
    } status_in_t;

    typedef struct packed {
        logic auto_crossover_enable;
        logic rx_out_en;
        logic vendor_access_en;
        logic test_mux_select;
        logic jabber_check_en;
        logic polarity_invert;
        logic sqe_test_en;
        logic link_force_pass;
        logic squelch_en;
    } ctrl_out_t;
endpackage

// [src/latch_flag.sv]
/*
 * one latched status flag, high-latching or low-latching.
 * assumes the one-cycle clear strobe marks the moment the owning register is read.
 */
`timescale 1ns/1ps
module latch_flag #(
    parameter bit LATCH_LOW = 1'b0
) (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    input  wire logic i_cond,
    input  wire logic i_clr,
    output logic      o_val
);
    logic seen;
    logic event_now;

    assign event_now = LATCH_LOW ? !i_cond : i_cond;

    // a fresh event beats the read clear; a standing condition re-latches
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            seen <= LATCH_LOW;
        end else begin
            seen <= event_now | (seen & !i_clr);
        end
    end

    assign o_val = LATCH_LOW ? !seen : seen;
endmodule

// [testbench/mgmt_station.sv]
/*
 * station management model: drives mdc and the shared mdio line.
 * assumes mdc at a tenth of the core clock and a pull-up at mdio.
 */
`timescale 1ns/1ps
module mgmt_station (
    input  wire logic i_core_clk,
    input  wire logic i_dut_mdio,
    input  wire logic i_dut_mdio_oe,
    output logic      o_mdc,
    output logic      o_line
);
    logic drv_en;
    logic drv_val;

    // released line floats to the pull-up level
    assign o_line = i_dut_mdio_oe ? i_dut_mdio : (drv_en ? drv_val : 1'b1);

    initial begin
        o_mdc   = 1'b0;
        drv_en  = 1'b0;
        drv_val = 1'b1;
    end

    // one full frame; mdc stands still low outside frames
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta_ok);
        logic [63:0] bits;
        bits = {32'hffff_ffff, 2'h1, op, phy, ra, 2'h2, wd};
        rd = 16'h0000;
        ta_ok = 1'b0;
        for (int i = 0; i < 66; i++) begin
            @(posedge i_core_clk);
            o_mdc <= 1'b0;
            drv_en <= (i < 46) || (op == 2'h1 && i < 64);
            drv_val <= (i < 64) ? bits[63-i] : 1'b1;
            repeat (4) @(posedge i_core_clk);
            // sampled late in the low phase, well after the slave's update
            if (i == 47)
                ta_ok = (o_line === 1'b0) && (i_dut_mdio_oe === 1'b1);
            if (i >= 49 && i <= 64)
                rd[64-i] = o_line;
            @(posedge i_core_clk);
            o_mdc <= 1'b1;
            repeat (4) @(posedge i_core_clk);
        end
        @(posedge i_core_clk);
        o_mdc <= 1'b0;
        drv_en <= 1'b0;
    endtask
endmodule

// [testbench/tb.sv]
/*
 * self-checking bench for the status and 10base-t operations registers.
 * assumes the station model is the only master of the management pins.
 */
`timescale 1ns/1ps
module tb;
    logic                     i_core_clk;
    logic                     i_srst;
    logic [2:0]               i_strap;
    phy_mgmt_pkg::status_in_t i_stat;
    phy_mgmt_pkg::status_in_t quiet;
    phy_mgmt_pkg::status_in_t ev;
    phy_mgmt_pkg::ctrl_out_t  o_ctrl;
    logic                     o_mdio;
    logic                     o_mdio_oe;
    wire logic                mdc;
    wire logic                line;
    logic [15:0]              rd;
    logic                     ta;
    int                       mismatches = 0;
    int                       n_checks = 0;

    phy_status_and_tenbase_ctrl_regs dut (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_mdc(mdc), .i_mdio(line), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
        .i_strap(i_strap), .i_stat(i_stat), .o_ctrl(o_ctrl));

    mgmt_station sta (.i_core_clk(i_core_clk), .i_dut_mdio(o_mdio),
        .i_dut_mdio_oe(o_mdio_oe), .o_mdc(mdc), .o_line(line));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rdr(input logic [4:0] ra, input logic [15:0] exp);
        sta.frame(phy_mgmt_pkg::OP_READ, phy_mgmt_pkg::PHY_ADDR_DFLT, ra, 16'h0000, rd, ta);
        chk(rd, exp, "read data");
        chk({15'h0000, ta}, 16'h0001, "turnaround");
    endtask

    task automatic wrr(input logic [4:0] ra, input logic [15:0] wd, input logic [4:0] phy);
        sta.frame(phy_mgmt_pkg::OP_WRITE, phy, ra, wd, rd, ta);
    endtask

    task automatic ctl(input logic [8:0] exp);
        chk({7'h00, o_ctrl}, {7'h00, exp}, "control outputs");
    endtask

    task automatic strobe_stat(input phy_mgmt_pkg::status_in_t v);
        @(posedge i_core_clk);
        i_stat <= v;
        @(posedge i_core_clk);
        i_stat <= quiet;
        repeat (3) @(posedge i_core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        i_srst = 1'b1;
        i_strap = 3'h5;
        quiet = '0;
        quiet.link_ok = 1'b1;
        i_stat = quiet;
        repeat (4) @(posedge i_core_clk);
        i_srst <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'h0000);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'h0001);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2a10);
        ctl(9'h195);
        $display("test reset done");
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'hffff, phy_mgmt_pkg::PHY_ADDR_DFLT);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2f3f);
        ctl(9'h122);
        wrr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'hffff, phy_mgmt_pkg::PHY_ADDR_DFLT);
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h0000, 5'h02);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'h0001);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2f3f);
        rdr(phy_mgmt_pkg::ADDR_VENDOR_LO, 16'h0000);
        sta.frame(phy_mgmt_pkg::OP_READ, 5'h02, phy_mgmt_pkg::ADDR_TB_OPS, 16'h0000, rd, ta);
        chk(rd, 16'hffff, "foreign address drove the line");
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h0000, phy_mgmt_pkg::PHY_ADDR_DFLT);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2000);
        ctl(9'h0d5);
        $display("test writes done");
        quiet.polarity_reversed = 1'b1;
        strobe_stat(quiet);
        chk({15'h0000, o_ctrl.polarity_invert}, 16'h0001, "auto polarity");
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h0008, phy_mgmt_pkg::PHY_ADDR_DFLT);
        chk({15'h0000, o_ctrl.polarity_invert}, 16'h0000, "polarity inhibit");
        quiet.polarity_reversed = 1'b0;
        strobe_stat(quiet);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h6008);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2008);
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h0000, phy_mgmt_pkg::PHY_ADDR_DFLT);
        $display("test polarity done");
        quiet.rate_100 = 1'b1;
        quiet.an_complete = 1'b1;
        quiet.an_progress = 3'h5;
        ev = quiet;
        {ev.tx_signal_lost, ev.pll_lock_err, ev.false_carrier, ev.invalid_symbol} = 4'hf;
        {ev.halt_symbol, ev.premature_end, ev.jabber, ev.remote_fault} = 4'hf;
        {ev.remote_jabber, ev.polarity_reversed, ev.link_ok} = 3'h6;
        strobe_stat(ev);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'haff6);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'he000);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'ha811);
        rdr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h2000);
        $display("test latched flags done");
        quiet.halt_symbol = 1'b1;
        strobe_stat(quiet);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'ha851);
        quiet.halt_symbol = 1'b0;
        strobe_stat(quiet);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'ha851);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'ha811);
        wrr(phy_mgmt_pkg::ADDR_TB_OPS, 16'h0020, phy_mgmt_pkg::PHY_ADDR_DFLT);
        ev = quiet;
        ev.jabber = 1'b1;
        strobe_stat(ev);
        rdr(phy_mgmt_pkg::ADDR_QP_STATUS, 16'ha811);
        $display("test held cause and jabber inhibit done");
        tally_and_finish();
    end
endmodule
